// ==== rtl/module_glue_consts.vh ====
`ifndef MODULE_GLUE_CONSTS_VH
`define MODULE_GLUE_CONSTS_VH
// ----------------------------------------
// Memory map
// ----------------------------------------
`define ONCHIP_BASE 32'h80000000
`define ONCHIP_LAST 32'h80000FFF
`define DRAM_BASE 32'h80001000
`define DRAM_LAST 32'h80400FFF
`define DRAM_OFS_BITS 22
`define DRAM_OFS_SUB 22'h001000
// ----------------------------------------
// Timing
// ----------------------------------------
`define CLK_PERIOD_NS 10
`define DRAM_CYCLE_NS 160
`define DRAM_CYCLE_CLKS (`DRAM_CYCLE_NS / `CLK_PERIOD_NS)
`define WAIT_STATES 1
`define RATE_SLOW_MBPS 10
`define RATE_FAST_MBPS 20
`define CLK_MHZ 100
`define DIV_SLOW (`CLK_MHZ / `RATE_SLOW_MBPS)
`define DIV_FAST (`CLK_MHZ / `RATE_FAST_MBPS)
// Last count of the bit pacers and of the DRAM wait counter
`define TICK_LAST_SLOW 8'h09
`define TICK_LAST_FAST 8'h04
`define DRAM_WAIT_LAST 4'hE
`endif

// ==== rtl/link_bit_tick.v ====
`include "module_glue_consts.vh"
module link_bit_tick (
  input wire clk,
  input wire rst,
  input wire fast,
  output reg tick
);
  reg [7:0] cnt_reg;
  wire [7:0] last = fast ? `TICK_LAST_FAST : `TICK_LAST_SLOW;
  always @(posedge clk) begin
    if (rst) begin
      cnt_reg <= 8'h00;
      tick <= 1'b0;
    end else if (cnt_reg >= last) begin
      cnt_reg <= 8'h00;
      tick <= 1'b1;
    end else begin
      cnt_reg <= cnt_reg + 8'h01;
      tick <= 1'b0;
    end
  end
endmodule // link_bit_tick

// ==== rtl/module_glue.v ====
`include "module_glue_consts.vh"
// What this block does
// - On-chip RAM answers the lowest 4 Kbytes, before external memory.
// - DRAM follows on-chip RAM, 80001000 to 80400FFF, 4 Mbytes.
// - DRAM repeats in 4 Mbyte blocks through all higher addresses.
// - Every DRAM access has one wait state, a 160 ns cycle.
// - First rate select sets link 0; second sets links 1 to 3.
// - Select low gives 10 Mbit/s, high gives 20 Mbit/s.
// - Fault output pulled low on error, otherwise released.
// - Names marked low are active low; all others active high.
// - An unconnected receive line reads low and keeps its link idle.
// - Links keep the standard protocol; only terminations differ.
module module_glue (
  input wire clk,
  input wire rst,
  input wire [31:0] cpu_addr,
  input wire cpu_req,
  input wire cpu_error,
  input wire link0_rate_select,
  input wire links123_rate_select,
  input wire [3:0] serial_rx_lines,
  output reg onchip_sel,
  output reg dram_sel,
  output reg [21:0] dram_offset,
  output reg cpu_ready,
  output reg [3:0] link_bit_tick,
  output reg [3:0] serial_rx_sync,
  output reg module_fault_low_o,
  output reg module_fault_low_oe
);
  // ----------------------------------------
  // Rate select synchronisers
  // ----------------------------------------
  // Select pins may move at any time, so three stages guard each one
  reg link0_sel_s1_reg;
  reg link0_sel_s2_reg;
  reg link0_sel_s3_reg;
  reg link0_fast_reg;
  reg links123_sel_s1_reg;
  reg links123_sel_s2_reg;
  reg links123_sel_s3_reg;
  reg links123_fast_reg;
  always @(posedge clk) begin
    if (rst) begin
      link0_sel_s1_reg <= 1'b0;
      link0_sel_s2_reg <= 1'b0;
      link0_sel_s3_reg <= 1'b0;
    end else begin
      link0_sel_s1_reg <= link0_rate_select;
      link0_sel_s2_reg <= link0_sel_s1_reg;
      link0_sel_s3_reg <= link0_sel_s2_reg;
    end
  end
  // Accept a change only when stages two and three agree
  always @(posedge clk) begin
    if (rst) begin
      link0_fast_reg <= 1'b0;
    end else if (link0_sel_s2_reg == link0_sel_s3_reg) begin
      link0_fast_reg <= link0_sel_s3_reg;
    end
  end
  always @(posedge clk) begin
    if (rst) begin
      links123_sel_s1_reg <= 1'b0;
      links123_sel_s2_reg <= 1'b0;
      links123_sel_s3_reg <= 1'b0;
    end else begin
      links123_sel_s1_reg <= links123_rate_select;
      links123_sel_s2_reg <= links123_sel_s1_reg;
      links123_sel_s3_reg <= links123_sel_s2_reg;
    end
  end
  always @(posedge clk) begin
    if (rst) begin
      links123_fast_reg <= 1'b0;
    end else if (links123_sel_s2_reg == links123_sel_s3_reg) begin
      links123_fast_reg <= links123_sel_s3_reg;
    end
  end
  // ----------------------------------------
  // Receive line synchronisers
  // ----------------------------------------
  reg [3:0] rx_s1_reg;
  reg [3:0] rx_s2_reg;
  reg [3:0] rx_s3_reg;
  wire [3:0] rx_sync_next;
  always @(posedge clk) begin
    if (rst) begin
      rx_s1_reg <= 4'h0;
      rx_s2_reg <= 4'h0;
      rx_s3_reg <= 4'h0;
    end else begin
      rx_s1_reg <= serial_rx_lines;
      rx_s2_reg <= rx_s1_reg;
      rx_s3_reg <= rx_s2_reg;
    end
  end
  genvar b;
  generate
    for (b = 0; b < 4; b = b + 1) begin : g_rx
      // Old level holds while stages two and three disagree
      assign rx_sync_next[b] = (rx_s2_reg[b] == rx_s3_reg[b]) ? rx_s3_reg[b]
                                                             : serial_rx_sync[b];
    end
  endgenerate
  // Floating inputs settle low off chip, so idle reads as 0
  always @(posedge clk) begin
    if (rst) begin
      serial_rx_sync <= 4'h0;
    end else begin
      serial_rx_sync <= rx_sync_next;
    end
  end
  // ----------------------------------------
  // Link bit rate
  // ----------------------------------------
  // Link 0 has its own select; links 1 to 3 share one
  wire [3:0] link_fast_w;
  wire [3:0] tick_w;
  assign link_fast_w = {links123_fast_reg, links123_fast_reg, links123_fast_reg,
                        link0_fast_reg};
  genvar i;
  generate
    for (i = 0; i < 4; i = i + 1) begin : g_link
      link_bit_tick u_tick (
        .clk(clk),
        .rst(rst),
        .fast(link_fast_w[i]),
        .tick(tick_w[i])
      );
    end
  endgenerate
  // Framing of each link is left unchanged; only pacing is set here
  always @(posedge clk) begin
    if (rst) begin
      link_bit_tick <= 4'h0;
    end else begin
      link_bit_tick <= tick_w;
    end
  end
  // ----------------------------------------
  // Address decode
  // ----------------------------------------
  localparam [1:0] HIT_NONE = 2'h0;
  localparam [1:0] HIT_ONCHIP = 2'h1;
  localparam [1:0] HIT_DRAM = 2'h2;
  reg [1:0] hit_class;
  always @* begin
    hit_class = HIT_NONE;
    if ((cpu_addr >= `ONCHIP_BASE) && (cpu_addr <= `ONCHIP_LAST)) begin
      hit_class = HIT_ONCHIP;
    end else if (cpu_addr >= `DRAM_BASE) begin
      hit_class = HIT_DRAM;
    end else begin
      hit_class = HIT_NONE;
    end
  end
  // Higher bits ignored, so every 4 Mbyte block aliases
  wire [21:0] ofs_low_w;
  wire [21:0] ofs_w;
  assign ofs_low_w = cpu_addr[`DRAM_OFS_BITS-1:0];
  assign ofs_w = ofs_low_w - `DRAM_OFS_SUB;
  // ----------------------------------------
  // Access sequencer
  // ----------------------------------------
  localparam [1:0] ST_IDLE = 2'b00;
  localparam [1:0] ST_WAIT = 2'b01;
  reg [1:0] state_reg;
  reg [1:0] state_next;
  reg [3:0] wait_cnt_reg;
  reg [3:0] wait_cnt_next;
  reg onchip_sel_next;
  reg dram_sel_next;
  reg [21:0] dram_offset_next;
  reg cpu_ready_next;
  always @* begin
    state_next = state_reg;
    wait_cnt_next = wait_cnt_reg;
    onchip_sel_next = 1'b0;
    dram_sel_next = dram_sel;
    dram_offset_next = dram_offset;
    cpu_ready_next = 1'b0;
    case (state_reg)
      ST_IDLE: begin
        dram_sel_next = 1'b0;
        // Ready still high means this request was just answered
        if (cpu_req && !cpu_ready) begin
          if (hit_class == HIT_ONCHIP) begin
            onchip_sel_next = 1'b1;
            cpu_ready_next = 1'b1;
          end else if (hit_class == HIT_DRAM) begin
            dram_sel_next = 1'b1;
            dram_offset_next = ofs_w;
            wait_cnt_next = 4'h0;
            state_next = ST_WAIT;
          end
        end
      end
      ST_WAIT: begin
        // One wait state stretches the access to 16 clocks
        if (wait_cnt_reg == `DRAM_WAIT_LAST) begin
          cpu_ready_next = 1'b1;
          dram_sel_next = 1'b0;
          state_next = ST_IDLE;
        end else begin
          wait_cnt_next = wait_cnt_reg + 4'h1;
        end
      end
      default: begin
        dram_sel_next = 1'b0;
        state_next = ST_IDLE;
      end
    endcase
  end
  always @(posedge clk) begin
    if (rst) begin
      state_reg <= ST_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end
  always @(posedge clk) begin
    if (rst) begin
      wait_cnt_reg <= 4'h0;
    end else begin
      wait_cnt_reg <= wait_cnt_next;
    end
  end
  always @(posedge clk) begin
    if (rst) begin
      onchip_sel <= 1'b0;
    end else begin
      onchip_sel <= onchip_sel_next;
    end
  end
  always @(posedge clk) begin
    if (rst) begin
      dram_sel <= 1'b0;
    end else begin
      dram_sel <= dram_sel_next;
    end
  end
  // Offset stays put between accesses, so the array sees no glitch
  always @(posedge clk) begin
    if (rst) begin
      dram_offset <= 22'h000000;
    end else begin
      dram_offset <= dram_offset_next;
    end
  end
  always @(posedge clk) begin
    if (rst) begin
      cpu_ready <= 1'b0;
    end else begin
      cpu_ready <= cpu_ready_next;
    end
  end
  // ----------------------------------------
  // Fault output, open drain
  // ----------------------------------------
  always @(posedge clk) begin
    if (rst) begin
      module_fault_low_o <= 1'b0;
    end else begin
      // Never drive high, so several modules can share the line
      module_fault_low_o <= 1'b0;
    end
  end
  always @(posedge clk) begin
    if (rst) begin
      module_fault_low_oe <= 1'b0;
    end else begin
      module_fault_low_oe <= cpu_error;
    end
  end
endmodule // module_glue

// ==== test/module_glue_asserts.sv ====
module module_glue_asserts (
  input wire clk,
  input wire rst,
  input wire cpu_error,
  input wire onchip_sel,
  input wire dram_sel,
  input wire cpu_ready,
  input wire [31:0] cpu_addr,
  input wire [21:0] dram_offset,
  input wire [3:0] serial_rx_lines,
  input wire [3:0] link_bit_tick,
  input wire [3:0] serial_rx_sync,
  input wire module_fault_low_o,
  input wire module_fault_low_oe
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  sequence dram_go; $rose(dram_sel); endsequence
  sequence dram_end; ##15 !dram_sel && cpu_ready; endsequence
  a_dram_wait: assert property (dram_go |-> dram_end)
    else $error("dram wait");
  a_onchip_hit: assert property (onchip_sel |-> cpu_ready && cpu_addr[31:12] == 20'h80000)
    else $error("onchip");
  a_dram_range: assert property (dram_go |-> cpu_addr >= 32'h80001000)
    else $error("range");
  a_dram_offset: assert property (dram_go |-> dram_offset == cpu_addr[21:0] - 22'h1000)
    else $error("offset");
  a_fault_follow: assert property (!$past(rst) |-> module_fault_low_oe == $past(cpu_error))
    else $error("fault");
  a_fault_open: assert property (module_fault_low_o == 1'b0)
    else $error("drive");
  a_tick_gap: assert property (link_bit_tick[0] |=> !link_bit_tick[0] [*4])
    else $error("tick");
  a_rx_idle: assert property ((serial_rx_lines == 4'h0) [*8] |-> serial_rx_sync == 4'h0)
    else $error("rx");
endmodule // module_glue_asserts
bind module_glue module_glue_asserts u_chk (
  .clk(clk),
  .rst(rst),
  .cpu_error(cpu_error),
  .onchip_sel(onchip_sel),
  .dram_sel(dram_sel),
  .cpu_ready(cpu_ready),
  .cpu_addr(cpu_addr),
  .dram_offset(dram_offset),
  .serial_rx_lines(serial_rx_lines),
  .link_bit_tick(link_bit_tick),
  .serial_rx_sync(serial_rx_sync),
  .module_fault_low_o(module_fault_low_o),
  .module_fault_low_oe(module_fault_low_oe)
);

// ==== test/carrier_model.sv ====
module carrier_model (
  input wire oe,
  input wire o,
  input wire [3:0] en,
  input wire [3:0] val,
  output wire [3:0] rx,
  output wire fault_line_low
);
  timeunit 1ns;
  timeprecision 1ns;
  // Board pull-up wins whenever nobody sinks
  assign fault_line_low = oe ? o : 1'b1;
  // Pull-down on undriven receive lines
  assign rx = en & val;
endmodule // carrier_model

// ==== test/module_glue_tb_top.sv ====
module module_glue_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0, rst = 1'b1, cpu_req = 1'b0, cpu_error = 1'b0, s0 = 1'b0, s1 = 1'b0;
  logic [31:0] cpu_addr = 32'h0;
  logic [3:0] en = 4'h0, val = 4'h0, rx, tick, sync;
  logic onchip_sel, dram_sel, cpu_ready, f_o, f_oe, fault_line_low;
  logic [21:0] ofs;
  int mismatches = 0, check_count = 0;
  module_glue u_dut (.clk(clk), .rst(rst), .cpu_addr(cpu_addr), .cpu_req(cpu_req),
    .cpu_error(cpu_error), .link0_rate_select(s0), .links123_rate_select(s1),
    .serial_rx_lines(rx), .onchip_sel(onchip_sel), .dram_sel(dram_sel), .dram_offset(ofs),
    .cpu_ready(cpu_ready), .link_bit_tick(tick), .serial_rx_sync(sync),
    .module_fault_low_o(f_o), .module_fault_low_oe(f_oe));
  carrier_model u_far (.oe(f_oe), .o(f_o), .en(en), .val(val), .rx(rx),
    .fault_line_low(fault_line_low));
  initial forever #5 clk = ~clk;
  task chk(input logic [31:0] got, exp);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD %0t %h %h", $time, got, exp);
    end
  endtask
  task acc(input logic [31:0] a, input logic [1:0] k, input logic [21:0] o);
    int i;
    @(posedge clk);
    cpu_addr <= a;
    cpu_req <= 1'b1;
    for (i = 0; i < 30 && cpu_ready !== 1'b1; i++) begin
      @(posedge clk);
      #1;
    end
    chk(cpu_ready, k != 0);
    chk(onchip_sel, k == 1);
    if (k != 0) chk(i, k == 2 ? 16 : 1);
    if (k == 2) chk(ofs, o);
    if (k == 2) chk(dram_sel, 1'b0);
    @(posedge clk) cpu_req <= 1'b0;
  endtask
  task rate(input logic a, b);
    logic [7:0] n0, n1;
    n0 = 8'h0;
    n1 = 8'h0;
    @(posedge clk);
    s0 <= a;
    s1 <= b;
    repeat (20) @(posedge clk);
    repeat (40) begin
      @(posedge clk);
      #1;
      n0 += tick[0];
      n1 += tick[1] & tick[2] & tick[3];
    end
    chk(n0, a ? 8 : 4);
    chk(n1, b ? 8 : 4);
  endtask
  task fault_rx;
    @(posedge clk) cpu_error <= 1'b1;
    repeat (2) @(posedge clk);
    #1 chk(fault_line_low, 1'b0);
    @(posedge clk) cpu_error <= 1'b0;
    en <= 4'hF;
    val <= 4'h9;
    repeat (10) @(posedge clk);
    #1 chk({fault_line_low, sync}, 5'h19);
    @(posedge clk) en <= 4'h0;
    repeat (10) @(posedge clk);
    #1 chk(sync, 4'h0);
  endtask
  task test_done;
    if (mismatches == 0 && check_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // Generous margin over a run of a few microseconds
  initial begin
    #50000;
    mismatches++;
    test_done;
  end
  initial begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    acc(32'h80000FFF, 2'd1, 22'h0);
    acc(32'h80001000, 2'd2, 22'h0);
    acc(32'h80400FFF, 2'd2, 22'h3FFFFF);
    acc(32'hFFFFFFFF, 2'd2, 22'h3FEFFF);
    acc(32'h7FFFFFFF, 2'd0, 22'h0);
    for (int i = 0; i < 4; i++) rate(i[0], i[1]);
    fault_rx;
    test_done;
  end
endmodule // module_glue_tb_top
